// ==== common/gbtc_pkg.sv ====
// constants and carrier types for the gate and timed-burst trigger control
// assumes one 100 MHz clock; times are held as clock-cycle counts
package gbtc_pkg;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_PS = 10000;
  localparam int MARGIN_PS     = 2500000;
  localparam int MARGIN_CYC    = (MARGIN_PS + CLK_PERIOD_PS - 1)
                                 / CLK_PERIOD_PS;
  localparam int CNT_W         = 32;
  localparam int LVL_W         = 12;
  localparam int NCH           = 2;

  // ==========================================================================
  // modes and sources
  typedef enum logic [1:0] {
    GBTC_MODE_CONT  = 2'b00,
    GBTC_MODE_GATE  = 2'b01,
    GBTC_MODE_BURST = 2'b10
  } gbtc_mode_e;

  typedef enum logic [1:0] {
    GBTC_ST_IDLE  = 2'b00,
    GBTC_ST_DELAY = 2'b01,
    GBTC_ST_RUN   = 2'b10
  } gbtc_state_e;

  typedef struct packed {
    gbtc_mode_e           mode;
    logic                 src_internal;
    logic                 polarity_pos;
    logic [LVL_W-1:0]     gate_level;
    logic [CNT_W-1:0]     trig_period;
    logic [CNT_W-1:0]     trig_delay;
  } gbtc_cfg_s;

  typedef struct packed {
    logic                 sweep_on;
    logic                 mod_on;
    logic                 am_ext_or_ch1;
    logic [CNT_W-1:0]     burst_output_time;
  } gbtc_chcfg_s;

endpackage

// ==== logic/gbtc_trigger.sv ====
// gate and timed-burst trigger control for two waveform channels
// assumes synchronous inputs, a sample of the external gate input as an
// unsigned code, and a waveform engine that reports the end of one repetition
`timescale 1ns/10ps
module gbtc_trigger
  import gbtc_pkg::*;
(
  input  wire logic                  clock_i,
  input  wire logic                  rst_i,
  input  wire gbtc_cfg_s             cfg_i,
  input  wire gbtc_chcfg_s [NCH-1:0] ch_cfg_i,
  input  wire logic [LVL_W-1:0]      ext_sample_i,
  input  wire logic [NCH-1:0]        rep_done_i,
  output logic [NCH-1:0]             out_en_o,
  output logic [NCH-1:0]             restart_o,
  output logic                       cfg_ok_o,
  output logic                       trig_o
);

  // ==========================================================================
  // gate qualification
  logic ext_asserted;
  logic int_gate;
  logic gate_raw;
  logic gate_on;
  logic gate_on_q;

  assign ext_asserted = (ext_sample_i >= cfg_i.gate_level);
  assign gate_raw = cfg_i.src_internal ? int_gate : ext_asserted;
  assign gate_on = cfg_i.polarity_pos ? gate_raw : !gate_raw;

  // registered copy marks gate rises for the restart pulse
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      gate_on_q <= 1'b0;
    end else begin
      gate_on_q <= gate_on;
    end
  end

  // ==========================================================================
  // period check; a violating setting holds the burst engine off
  logic [CNT_W+1:0] need_max;
  logic [CNT_W+1:0] need_ch [NCH];

  function automatic logic uses_rep(input gbtc_chcfg_s c);
    return (c.sweep_on || c.mod_on) && !c.am_ext_or_ch1;
  endfunction

  always_comb begin
    need_max = '0;
    for (int i = 0; i < NCH; i++) begin
      need_ch[i] = (CNT_W+2)'(cfg_i.trig_delay)
                 + (CNT_W+2)'(ch_cfg_i[i].burst_output_time)
                 + (CNT_W+2)'(MARGIN_CYC);
      if (need_ch[i] > need_max) begin
        need_max = need_ch[i];
      end
    end
  end

  logic cfg_ok;
  // rejecting rather than clamping keeps every programmed time exact
  // reject bad ordering
  assign cfg_ok = (CNT_W+2)'(cfg_i.trig_period) > need_max;
  assign cfg_ok_o = cfg_ok;

  // ==========================================================================
  // shared internal trigger period
  logic [CNT_W-1:0] per_cnt;
  logic             trig;
  logic             burst_go;

  assign burst_go = (cfg_i.mode == GBTC_MODE_BURST) && cfg_ok;
  assign trig = burst_go && (per_cnt == '0);
  assign trig_o = trig;
  assign int_gate = trig;

  // both channels count off this one counter, so their bursts stay aligned
  // one period shared by both channels
  always_ff @(posedge clock_i) begin
    if (rst_i || !burst_go) begin
      per_cnt <= '0;
    end else if (per_cnt >= cfg_i.trig_period - 1'b1) begin
      per_cnt <= '0;
    end else begin
      per_cnt <= per_cnt + 1'b1;
    end
  end

  // ==========================================================================
  // per-channel burst engines
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    gbtc_state_e      state;
    logic [CNT_W-1:0] cnt;
    logic             rep_mode;
    logic             run_end;

    // external or channel-one am keeps time
    assign rep_mode = uses_rep(ch_cfg_i[c]);
    // a zero burst time wraps this compare; keep it non-zero in time mode
    assign run_end  = rep_mode ? rep_done_i[c]
                    : (cnt >= ch_cfg_i[c].burst_output_time - 1'b1);

    always_ff @(posedge clock_i) begin
      if (rst_i || !burst_go) begin
        state <= GBTC_ST_IDLE;
        cnt   <= '0;
      end else begin
        case (state)
          GBTC_ST_IDLE: begin
            if (trig) begin
              state <= GBTC_ST_DELAY;
              cnt   <= '0;
            end
          end
          GBTC_ST_DELAY: begin
            if (cnt >= cfg_i.trig_delay) begin
              state <= GBTC_ST_RUN;
              cnt   <= '0;
            end else begin
              cnt <= cnt + 1'b1;
            end
          end
          GBTC_ST_RUN: begin
            if (run_end) begin
              state <= GBTC_ST_IDLE;
            end
            cnt <= cnt + 1'b1;
          end
          default: state <= GBTC_ST_IDLE;
        endcase
      end
    end

    logic next_en;
    always_comb begin
      case (cfg_i.mode)
        GBTC_MODE_GATE:  next_en = gate_on;
        GBTC_MODE_BURST: next_en = (state == GBTC_ST_DELAY)
                                   && (cnt >= cfg_i.trig_delay);
        default:         next_en = 1'b1;
      endcase
    end

    always_ff @(posedge clock_i) begin
      if (rst_i) begin
        out_en_o[c]  <= 1'b0;
        restart_o[c] <= 1'b0;
      end else begin
        out_en_o[c] <= (cfg_i.mode == GBTC_MODE_BURST)
                       ? (next_en || (state == GBTC_ST_RUN && !run_end))
                       : next_en;
        // in burst mode restart marks the first output cycle of each burst
        // in gate mode restart only on gate rise, never while held
        restart_o[c] <= (cfg_i.mode == GBTC_MODE_GATE)
                        ? (gate_on && !gate_on_q)
                        : ((cfg_i.mode == GBTC_MODE_BURST) && next_en);
      end
    end

    // ========================================================================
    // checks
    gate_follow_a: assert property (@(posedge clock_i)
      disable iff (rst_i)
      cfg_i.mode == GBTC_MODE_GATE && $stable(cfg_i)
      |=> out_en_o[c] == $past(gate_on))
      else $error("gate output does not follow gate");
    no_restart_a: assert property (@(posedge clock_i) disable iff (rst_i)
      cfg_i.mode == GBTC_MODE_GATE && gate_on_q && gate_on |=> !restart_o[c])
      else $error("restart while gate held");
    delay_start_a: assert property (@(posedge clock_i)
      disable iff (rst_i)
      state == GBTC_ST_IDLE && trig |=> state == GBTC_ST_DELAY)
      else $error("trigger did not start delay");
    rep_end_a: assert property (@(posedge clock_i) disable iff (rst_i)
      burst_go && state == GBTC_ST_RUN && rep_mode && !rep_done_i[c]
      |=> state == GBTC_ST_RUN)
      else $error("repetition burst ended early");
    time_end_a: assert property (@(posedge clock_i) disable iff (rst_i)
      burst_go && state == GBTC_ST_RUN && !rep_mode
      && cnt >= ch_cfg_i[c].burst_output_time - 1'b1
      |=> state == GBTC_ST_IDLE)
      else $error("timed burst overran");
    burst_open_a: assert property (@(posedge clock_i) disable iff (rst_i)
      burst_go && state == GBTC_ST_DELAY && cnt >= cfg_i.trig_delay
      |=> out_en_o[c] && restart_o[c] && state == GBTC_ST_RUN)
      else $error("burst did not open after delay");
    reject_off_a: assert property (@(posedge clock_i) disable iff (rst_i)
      cfg_i.mode == GBTC_MODE_BURST && !cfg_ok
      ##1 cfg_i.mode == GBTC_MODE_BURST && !cfg_ok |=> !out_en_o[c])
      else $error("rejected setting still drives output");
    burst_cov: cover property (@(posedge clock_i) state == GBTC_ST_RUN);
    rep_cov: cover property (@(posedge clock_i)
      state == GBTC_ST_RUN && rep_mode && rep_done_i[c]);
  end

  polarity_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !cfg_i.src_internal && !cfg_i.polarity_pos
    |-> gate_on == (ext_sample_i < cfg_i.gate_level))
    else $error("polarity not applied");
  source_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !cfg_i.src_internal |-> gate_raw == (ext_sample_i >= cfg_i.gate_level))
    else $error("external source not selected");
  threshold_a: assert property (@(posedge clock_i) disable iff (rst_i)
    ext_sample_i < cfg_i.gate_level |-> !ext_asserted)
    else $error("threshold compare wrong");
  order_a: assert property (@(posedge clock_i) disable iff (rst_i)
    trig |-> cfg_i.trig_period > cfg_i.trig_delay + MARGIN_CYC)
    else $error("trigger with bad period");
  gate_cov: cover property (@(posedge clock_i)
    cfg_i.mode == GBTC_MODE_GATE && out_en_o[0]);
  trig_cov: cover property (@(posedge clock_i) trig ##1 !trig);
  reject_cov: cover property (@(posedge clock_i)
    cfg_i.mode == GBTC_MODE_BURST && !cfg_ok);

endmodule

// ==== tb/gbtc_gate_src.sv ====
// partner model: external gate source behind the sampled gate input
// assumes the bench changes its request at the falling clock edge
`timescale 1ns/10ps
module gbtc_gate_src
  import gbtc_pkg::*;
(
  input  wire logic             clock_i,
  input  wire logic             want_i,
  input  wire logic             pol_i,
  input  wire logic [LVL_W-1:0] level_i,
  output logic      [LVL_W-1:0] sample_o
);
  int unsigned r;

  // ==========================================================================
  // sample source
  // a fresh random code every cycle, so a stuck compare cannot hide
  // limitation: level_i must be non-zero
  always @(negedge clock_i) begin
    #1;
    r = $urandom;
    if (want_i == pol_i)
      sample_o = level_i + LVL_W'(r % ((1 << LVL_W) - level_i));
    else
      sample_o = LVL_W'(r % level_i);
  end
endmodule

// ==== tb/gbtc_trigger_tb.sv ====
// self-checking bench for the gate and timed-burst trigger control
// assumes the gate source model drives the sampled gate input
`timescale 1ns/10ps
`define CHK(g, e) cmp(32'(g), 32'(e))
module gbtc_trigger_tb
  import gbtc_pkg::*;
;
  logic                  clock_i, rst_i, want, g, pg;
  gbtc_cfg_s             cfg;
  gbtc_chcfg_s [NCH-1:0] chc;
  logic [LVL_W-1:0]      smp;
  logic [NCH-1:0]        done, out_en, restart;
  logic                  cfg_ok, trig;
  logic [3:0]            notes[$];
  int                    miscompares, num_checks, c0, c1, ct, h0;

  gbtc_trigger u_dut (.clock_i(clock_i), .rst_i(rst_i), .cfg_i(cfg),
    .ch_cfg_i(chc), .ext_sample_i(smp), .rep_done_i(done),
    .out_en_o(out_en), .restart_o(restart), .cfg_ok_o(cfg_ok), .trig_o(trig));
  gbtc_gate_src u_src (.clock_i(clock_i), .want_i(want),
    .pol_i(cfg.polarity_pos), .level_i(cfg.gate_level), .sample_o(smp));

  // ==========================================================================
  // helpers
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // three periods hold exactly three triggers whatever the first offset
  task automatic burst(input int p, input logic sw);
    logic ok;
    ok = p > 10 + 35 + MARGIN_CYC;
    {c0, c1, ct, h0} = '0;
    cfg.trig_period = CNT_W'(p);
    cfg.mode = GBTC_MODE_BURST;
    repeat (3 * p) begin
      @(negedge clock_i);
      c0 += out_en[0];
      c1 += out_en[1];
      ct += trig;
      h0 = out_en[0] ? h0 + 1 : 0;
      done <= {2{h0 == 50}};
    end
    `CHK(cfg_ok, ok);
    `CHK(ct, ok ? 3 : 0);
    if (sw) `CHK(c0, ok ? 150 : 0);
    else `CHK(c0, ok ? 60 : 0);
    `CHK(c1, ok ? 105 : 0);
    done <= '0;
    cfg.mode = GBTC_MODE_CONT;
    repeat (2) @(negedge clock_i);
    $display("burst test period %0d done", p);
  endtask

  // ==========================================================================
  // monitor: oldest note against the registered outputs
  always @(posedge clock_i) begin
    if (notes.size() > 0) begin
      #1;
      `CHK({out_en, restart}, notes.pop_front());
    end
  end

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  initial begin
    #100us;
    miscompares++;
    $display("timeout");
    test_done();
  end

  // ==========================================================================
  // stimulus
  initial begin
    void'($urandom(83325));
    {miscompares, num_checks} = '0;
    cfg = '0;
    cfg.mode = GBTC_MODE_CONT;
    cfg.gate_level = 12'h800;
    chc = '0;
    {want, done, rst_i} = {1'b0, 2'h0, 1'b1};
    repeat (5) @(negedge clock_i);
    rst_i = 1'b0;
    for (int k = 0; k < 2; k++) begin
      cfg.polarity_pos = k[0];
      cfg.gate_level = LVL_W'(1 + $urandom % 4094);
      {want, pg} = '0;
      repeat (2) @(negedge clock_i);
      cfg.mode = GBTC_MODE_GATE;
      repeat (80) begin
        @(negedge clock_i);
        g = 1'($urandom % 2);
        want = g;
        notes.push_back({{2{g}}, {2{g & ~pg}}});
        pg = g;
      end
      repeat (2) @(negedge clock_i);
      cfg.mode = GBTC_MODE_CONT;
      $display("gate test polarity %0d done", k);
    end
    cfg.src_internal = 1'b1;
    cfg.trig_delay = 10;
    chc[0].burst_output_time = 20;
    chc[1].burst_output_time = 35;
    burst(296, 1'b0);
    burst(295, 1'b0);
    // sweep on one channel, external am on the other
    chc[0].sweep_on = 1'b1;
    chc[1].mod_on = 1'b1;
    chc[1].am_ext_or_ch1 = 1'b1;
    burst(400, 1'b1);
    test_done();
  end
endmodule
